// ### inc/ipv_irq_regs.vh
// constants for the interrupt priority and vector logic
`ifndef IPV_IRQ_REGS_VH
`define IPV_IRQ_REGS_VH

// register word offsets, matched against haddr[7:2]
`define IPV_OFF_PRIO 6'h00
`define IPV_OFF_TMREN 6'h01
`define IPV_OFF_SEREN 6'h02
`define IPV_OFF_PHEN 6'h03
`define IPV_OFF_CFG 6'h04
`define IPV_OFF_STAT 6'h05

// field layouts
`define IPV_PSEL 4:0
`define IPV_PSEL_RST 5'h06
`define IPV_TEN_CAP 2:0
`define IPV_TEN_CMP 6:3
`define IPV_TEN_C45 7
`define IPV_TEN_TOF 8
`define IPV_TEN_PAOV 9
`define IPV_TEN_PAEDGE 10
`define IPV_TEN_RTI 11
`define IPV_TEN_W 12
`define IPV_SEN_A1 3:0
`define IPV_SEN_A2 7:4
`define IPV_SEN_S1 8
`define IPV_SEN_S2 9
`define IPV_SEN_MOD 12:10
`define IPV_SEN_W 13
`define IPV_CFG_NOWD 0
`define IPV_CFG_CME 1
`define IPV_ST_VEC 15:0
`define IPV_ST_SRC 20:16
`define IPV_ST_REQ 24

// source codes: 0..18 maskable in fixed order, then fixed class
`define IPV_SRC_IRQ 5'h00
`define IPV_SRC_RTI 5'h01
`define IPV_SRC_TOF 5'h0c
`define IPV_SRC_SYNC2 5'h0a
`define IPV_SRC_ASYNC2 5'h0b
`define IPV_SRC_MOD 5'h0d
`define IPV_SRC_PAOV 5'h0e
`define IPV_SRC_PAEDGE 5'h0f
`define IPV_SRC_PORTH 5'h10
`define IPV_SRC_SYNC1 5'h11
`define IPV_SRC_ASYNC1 5'h12
`define IPV_SRC_NONMASKABLE_PIN 5'h13
`define IPV_SRC_ILLOP 5'h14
`define IPV_SRC_SWI 5'h15
`define IPV_SRC_COP 5'h16
`define IPV_SRC_CMF 5'h17
`define IPV_SRC_RESET 5'h18
`define IPV_NMASK 19

// vector addresses, even byte of each pair
`define IPV_VEC_PORTH 16'hffce
`define IPV_VEC_MOD 16'hffd0
`define IPV_VEC_ASYNC2 16'hffd2
`define IPV_VEC_SYNC2 16'hffd4
`define IPV_VEC_ASYNC1 16'hffd6
`define IPV_VEC_SYNC1 16'hffd8
`define IPV_VEC_PAEDGE 16'hffda
`define IPV_VEC_PAOV 16'hffdc
`define IPV_VEC_TOF 16'hffde
`define IPV_VEC_C45 16'hffe0
`define IPV_VEC_CMP4 16'hffe2
`define IPV_VEC_IC3 16'hffea
`define IPV_VEC_RTI 16'hfff0
`define IPV_VEC_IRQ 16'hfff2
`define IPV_VEC_NONMASKABLE_PIN 16'hfff4
`define IPV_VEC_SWI 16'hfff6
`define IPV_VEC_ILLOP 16'hfff8
`define IPV_VEC_COP 16'hfffa
`define IPV_VEC_CMF 16'hfffc
`define IPV_VEC_RESET 16'hfffe
`define IPV_VEC_STEP 16'h0002

`endif

// ### rtl/ipv_irq_ctrl.v
// interrupt priority, promotion and vector logic with ahb-lite registers
`timescale 1ns/100ps
`default_nettype none
`include "ipv_irq_regs.vh"
module ipv_irq_ctrl
(
  input wire clk,
  input wire resetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire condCodeIBit,
  input wire condCodeXBit,
  input wire irqPinN,
  input wire nonmaskablePinN,
  input wire swiReq,
  input wire illegalOpReq,
  input wire copFail,
  input wire clockMonFail,
  input wire resetReq,
  input wire rtiFlag,
  input wire [2:0] captureFlag,
  input wire [3:0] compareFlag,
  input wire cap4Cmp5Flag,
  input wire timerOvfFlag,
  input wire accumOvfFlag,
  input wire accumEdgeFlag,
  input wire [2:0] modTimerFlag,
  input wire [7:0] porthFlag,
  input wire sync1DoneFlag,
  input wire sync2DoneFlag,
  input wire [1:0] asyncRxSet,
  input wire [1:0] asyncStatusRd,
  input wire [1:0] asyncDataRd,
  input wire [1:0] asyncOverrun,
  input wire [1:0] asyncTxEmpty,
  input wire [1:0] asyncTxDone,
  input wire [1:0] asyncIdle,
  output wire [1:0] rxFullFlag,
  output reg irqPending_ff,
  output reg [4:0] srcCode_ff,
  output reg [15:0] vecHiAddr_ff,
  output reg [15:0] vecLoAddr_ff
);

  // promotion code to maskable source index
  function [4:0] pselIdx;
    input [4:0] code;
    begin
      case (code)
        5'h06: pselIdx = `IPV_SRC_IRQ;
        5'h07: pselIdx = `IPV_SRC_RTI;
        5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f:
          pselIdx = code - 5'h06;
        5'h10: pselIdx = `IPV_SRC_TOF;
        5'h11: pselIdx = `IPV_SRC_PAOV;
        5'h12: pselIdx = `IPV_SRC_PAEDGE;
        5'h13: pselIdx = `IPV_SRC_SYNC1;
        5'h14: pselIdx = `IPV_SRC_ASYNC1;
        5'h15: pselIdx = `IPV_SRC_SYNC2;
        5'h16: pselIdx = `IPV_SRC_ASYNC2;
        5'h17: pselIdx = `IPV_SRC_MOD;
        5'h18: pselIdx = `IPV_SRC_PORTH;
        default: pselIdx = `IPV_SRC_IRQ;
      endcase
    end
  endfunction

  // maskable source index to vector, independent of rank
  function [15:0] vecOf;
    input [4:0] idx;
    begin
      case (idx)
        5'h00: vecOf = `IPV_VEC_IRQ;
        5'h01: vecOf = `IPV_VEC_RTI;
        5'h02, 5'h03, 5'h04:
          vecOf = `IPV_VEC_IC3 + (`IPV_VEC_STEP * (16'h0004 - {11'h000, idx}));
        5'h05, 5'h06, 5'h07, 5'h08:
          vecOf = `IPV_VEC_CMP4 + (`IPV_VEC_STEP * (16'h0008 - {11'h000, idx}));
        5'h09: vecOf = `IPV_VEC_C45;
        5'h0a: vecOf = `IPV_VEC_SYNC2;
        5'h0b: vecOf = `IPV_VEC_ASYNC2;
        5'h0c: vecOf = `IPV_VEC_TOF;
        5'h0d: vecOf = `IPV_VEC_MOD;
        5'h0e: vecOf = `IPV_VEC_PAOV;
        5'h0f: vecOf = `IPV_VEC_PAEDGE;
        5'h10: vecOf = `IPV_VEC_PORTH;
        5'h11: vecOf = `IPV_VEC_SYNC1;
        5'h12: vecOf = `IPV_VEC_ASYNC1;
        default: vecOf = `IPV_VEC_IRQ;
      endcase
    end
  endfunction

  // lowest set index wins in fixed order
  function [4:0] firstSet;
    input [`IPV_NMASK-1:0] req;
    integer i;
    begin
      firstSet = 5'h00;
      for (i = `IPV_NMASK - 1; i >= 0; i = i - 1)
      begin
        if (req[i])
        begin
          firstSet = i[4:0];
        end
      end
    end
  endfunction

  reg [4:0] psel_ff;
  reg [`IPV_TEN_W-1:0] tmrEn_ff;
  reg [`IPV_SEN_W-1:0] serEn_ff;
  reg [7:0] porthEn_ff;
  reg watchdogDisable_ff;
  reg clockMonEnable_ff;
  reg wrPend_ff;
  reg [5:0] wrIdx_ff;
  reg [31:0] nxt_rdata;
  reg nxt_pending;
  reg [4:0] nxt_src;
  reg [15:0] nxt_vec;

  wire addrPhase;
  wire [5:0] rdIdx;
  wire [1:0] asyncAny;
  wire [`IPV_NMASK-1:0] srcReq;
  wire [`IPV_NMASK-1:0] maskReq;
  wire [4:0] promIdx;
  wire [4:0] winIdx;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel && htrans[1] && hready;
  assign rdIdx = haddr[7:2];

  // receive-full flags of both async units
  genvar u;
  generate
    for (u = 0; u < 2; u = u + 1)
    begin : rxu
      ipv_rx_flag rxFlag
      (
        .clk(clk),
        .resetn(resetn),
        .rxSet(asyncRxSet[u]),
        .statusRd(asyncStatusRd[u]),
        .dataRd(asyncDataRd[u]),
        .rxFullFlag(rxFullFlag[u])
      );
    end
  endgenerate

  // five events per async unit onto one request
  assign asyncAny[0] = ((rxFullFlag[0] | asyncOverrun[0]) & serEn_ff[0])
    | (asyncTxEmpty[0] & serEn_ff[1]) | (asyncTxDone[0] & serEn_ff[2])
    | (asyncIdle[0] & serEn_ff[3]);
  assign asyncAny[1] = ((rxFullFlag[1] | asyncOverrun[1]) & serEn_ff[4])
    | (asyncTxEmpty[1] & serEn_ff[5]) | (asyncTxDone[1] & serEn_ff[6])
    | (asyncIdle[1] & serEn_ff[7]);

  // locally gated requests except the ungated irq pin (index 0), index is the fixed rank
  assign srcReq[0] = ~irqPinN;
  assign srcReq[1] = rtiFlag & tmrEn_ff[`IPV_TEN_RTI];
  assign srcReq[4:2] = captureFlag & tmrEn_ff[`IPV_TEN_CAP];
  assign srcReq[8:5] = compareFlag & tmrEn_ff[`IPV_TEN_CMP];
  assign srcReq[9] = cap4Cmp5Flag & tmrEn_ff[`IPV_TEN_C45];
  assign srcReq[10] = sync2DoneFlag & serEn_ff[`IPV_SEN_S2];
  assign srcReq[11] = asyncAny[1];
  assign srcReq[12] = timerOvfFlag & tmrEn_ff[`IPV_TEN_TOF];
  assign srcReq[13] = |(modTimerFlag & serEn_ff[`IPV_SEN_MOD]);
  assign srcReq[14] = accumOvfFlag & tmrEn_ff[`IPV_TEN_PAOV];
  assign srcReq[15] = accumEdgeFlag & tmrEn_ff[`IPV_TEN_PAEDGE];
  assign srcReq[16] = |(porthFlag & porthEn_ff);
  assign srcReq[17] = sync1DoneFlag & serEn_ff[`IPV_SEN_S1];
  assign srcReq[18] = asyncAny[0];

  // global mask applies to every maskable source, promoted or not
  assign maskReq = srcReq & {`IPV_NMASK{~condCodeIBit}};
  assign promIdx = pselIdx(psel_ff);
  assign winIdx = maskReq[promIdx] ? promIdx : firstSet(maskReq);

  // fixed class first, then maskable winner
  always @*
  begin
    nxt_pending = 1'b1;
    nxt_src = `IPV_SRC_IRQ;
    nxt_vec = `IPV_VEC_IRQ;
    if (resetReq)
    begin
      nxt_src = `IPV_SRC_RESET;
      nxt_vec = `IPV_VEC_RESET;
    end
    else if (clockMonFail && clockMonEnable_ff)
    begin
      nxt_src = `IPV_SRC_CMF;
      nxt_vec = `IPV_VEC_CMF;
    end
    else if (copFail && !watchdogDisable_ff)
    begin
      nxt_src = `IPV_SRC_COP;
      nxt_vec = `IPV_VEC_COP;
    end
    else if (!nonmaskablePinN && !condCodeXBit)
    begin
      nxt_src = `IPV_SRC_NONMASKABLE_PIN;
      nxt_vec = `IPV_VEC_NONMASKABLE_PIN;
    end
    else if (illegalOpReq)
    begin
      nxt_src = `IPV_SRC_ILLOP;
      nxt_vec = `IPV_VEC_ILLOP;
    end
    else if (swiReq)
    begin
      nxt_src = `IPV_SRC_SWI;
      nxt_vec = `IPV_VEC_SWI;
    end
    else if (|maskReq)
    begin
      nxt_src = winIdx;
      nxt_vec = vecOf(winIdx);
    end
    else
    begin
      nxt_pending = 1'b0;
    end
  end

  // outputs, pair addresses high byte first
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irqPending_ff <= 1'b0;
      srcCode_ff <= `IPV_SRC_IRQ;
      vecHiAddr_ff <= `IPV_VEC_IRQ;
      vecLoAddr_ff <= `IPV_VEC_IRQ;
    end
    else
    begin
      irqPending_ff <= nxt_pending;
      srcCode_ff <= nxt_src;
      vecHiAddr_ff <= nxt_vec;
      vecLoAddr_ff <= nxt_vec | 16'h0001;
    end
  end

  // read data prepared in the address phase
  always @*
  begin
    nxt_rdata = 32'h00000000;
    case (rdIdx)
      `IPV_OFF_PRIO: nxt_rdata[`IPV_PSEL] = psel_ff;
      `IPV_OFF_TMREN: nxt_rdata[`IPV_TEN_W-1:0] = tmrEn_ff;
      `IPV_OFF_SEREN: nxt_rdata[`IPV_SEN_W-1:0] = serEn_ff;
      `IPV_OFF_PHEN: nxt_rdata[7:0] = porthEn_ff;
      `IPV_OFF_CFG:
      begin
        nxt_rdata[`IPV_CFG_NOWD] = watchdogDisable_ff;
        nxt_rdata[`IPV_CFG_CME] = clockMonEnable_ff;
      end
      `IPV_OFF_STAT:
      begin
        nxt_rdata[`IPV_ST_VEC] = vecHiAddr_ff;
        nxt_rdata[`IPV_ST_SRC] = srcCode_ff;
        nxt_rdata[`IPV_ST_REQ] = irqPending_ff;
      end
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  // ahb-lite slave, zero wait states
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPend_ff <= 1'b0;
      wrIdx_ff <= 6'h00;
      hrdata <= 32'h00000000;
    end
    else
    begin
      wrPend_ff <= addrPhase && hwrite;
      if (addrPhase)
      begin
        wrIdx_ff <= rdIdx;
      end
      if (addrPhase && !hwrite)
      begin
        hrdata <= nxt_rdata;
      end
    end
  end

  // register writes in the data phase
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      psel_ff <= `IPV_PSEL_RST;
      tmrEn_ff <= {`IPV_TEN_W{1'b0}};
      serEn_ff <= {`IPV_SEN_W{1'b0}};
      porthEn_ff <= 8'h00;
      watchdogDisable_ff <= 1'b0;
      clockMonEnable_ff <= 1'b0;
    end
    else if (wrPend_ff)
    begin
      case (wrIdx_ff)
        `IPV_OFF_PRIO:
        begin
          if (condCodeIBit)
          begin
            psel_ff <= hwdata[`IPV_PSEL];
          end
        end
        `IPV_OFF_TMREN: tmrEn_ff <= hwdata[`IPV_TEN_W-1:0];
        `IPV_OFF_SEREN: serEn_ff <= hwdata[`IPV_SEN_W-1:0];
        `IPV_OFF_PHEN: porthEn_ff <= hwdata[7:0];
        `IPV_OFF_CFG:
        begin
          watchdogDisable_ff <= hwdata[`IPV_CFG_NOWD];
          clockMonEnable_ff <= hwdata[`IPV_CFG_CME];
        end
        default:
        begin
          porthEn_ff <= porthEn_ff;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### rtl/ipv_rx_flag.v
// receive-full flag with status-then-data read clearing
`timescale 1ns/100ps
`default_nettype none
module ipv_rx_flag
(
  input wire clk,
  input wire resetn,
  input wire rxSet,
  input wire statusRd,
  input wire dataRd,
  output reg rxFullFlag
);

  reg armed_ff;
  reg nxt_armed;
  reg nxt_flag;

  always @*
  begin
    nxt_armed = armed_ff;
    nxt_flag = rxFullFlag;
    if (statusRd && rxFullFlag)
    begin
      nxt_armed = 1'b1;
    end
    if (dataRd && armed_ff)
    begin
      nxt_flag = 1'b0;
      nxt_armed = 1'b0;
    end
    // a new byte wins over the clear
    if (rxSet)
    begin
      nxt_flag = 1'b1;
      nxt_armed = 1'b0;
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      armed_ff <= 1'b0;
      rxFullFlag <= 1'b0;
    end
    else
    begin
      armed_ff <= nxt_armed;
      rxFullFlag <= nxt_flag;
    end
  end

endmodule
`default_nettype wire

// ### sim/ipv_irq_ctrl_monitor.sv
// assertion checker on the interrupt block ports
`timescale 1ns/100ps
`default_nettype none
module ipv_irq_ctrl_monitor
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic condCodeIBit,
  input wire logic condCodeXBit,
  input wire logic nonmaskablePinN,
  input wire logic swiReq,
  input wire logic illegalOpReq,
  input wire logic copFail,
  input wire logic clockMonFail,
  input wire logic resetReq,
  input wire logic [1:0] asyncRxSet,
  input wire logic [1:0] asyncDataRd,
  input wire logic [1:0] rxFullFlag,
  input wire logic irqPending_ff,
  input wire logic [4:0] srcCode_ff,
  input wire logic [15:0] vecHiAddr_ff,
  input wire logic [15:0] vecLoAddr_ff
);
  wire upper = !resetReq & !clockMonFail & !copFail;
  wire xOnly = upper & !nonmaskablePinN & !condCodeXBit;
  wire swiOnly = upper & nonmaskablePinN & !illegalOpReq & swiReq;
  wire quiet = condCodeIBit & nonmaskablePinN & !swiReq & !illegalOpReq & upper;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  AST_VEC_PAIR: assert property (irqPending_ff |-> vecLoAddr_ff == (vecHiAddr_ff | 16'h0001))
    else $error("low byte address not odd partner");
  AST_I_MASK: assert property (irqPending_ff && srcCode_ff < 5'h13 |-> !$past(condCodeIBit))
    else $error("maskable winner while masked");
  AST_IDLE: assert property ($past(quiet) |-> !irqPending_ff)
    else $error("request pending with all sources quiet");
  AST_RESET_TOP: assert property ($past(resetReq) |-> irqPending_ff && srcCode_ff == 5'h18
    && vecHiAddr_ff == 16'hfffe)
    else $error("reset request not on top vector");
  AST_NONMASKABLE_PIN_WIN: assert property ($past(xOnly) |-> srcCode_ff == 5'h13 && vecHiAddr_ff == 16'hfff4)
    else $error("nonmaskable pin lost or misvectored");
  AST_X_MASK: assert property (irqPending_ff && srcCode_ff == 5'h13 |-> !$past(condCodeXBit))
    else $error("nonmaskable pin taken while masked");
  AST_SWI_WIN: assert property ($past(swiOnly) |-> srcCode_ff == 5'h15 && vecHiAddr_ff == 16'hfff6)
    else $error("software interrupt lost or misvectored");
  AST_RX_SET: assert property (asyncRxSet[0] |=> rxFullFlag[0])
    else $error("receive flag not set");
  AST_RX_CLR: assert property ($fell(rxFullFlag[0]) |-> $past(asyncDataRd[0]))
    else $error("receive flag cleared without data read");
endmodule
bind ipv_irq_ctrl ipv_irq_ctrl_monitor mon (.clk(clk), .resetn(resetn), .hreadyout(hreadyout),
  .hresp(hresp), .condCodeIBit(condCodeIBit), .condCodeXBit(condCodeXBit),
  .nonmaskablePinN(nonmaskablePinN), .swiReq(swiReq), .illegalOpReq(illegalOpReq),
  .copFail(copFail), .clockMonFail(clockMonFail), .resetReq(resetReq),
  .asyncRxSet(asyncRxSet), .asyncDataRd(asyncDataRd), .rxFullFlag(rxFullFlag),
  .irqPending_ff(irqPending_ff), .srcCode_ff(srcCode_ff), .vecHiAddr_ff(vecHiAddr_ff),
  .vecLoAddr_ff(vecLoAddr_ff));
`default_nettype wire

// ### sim/ipv_irq_ctrl_tb_top.sv
// self-checking bench for the interrupt priority and vector block
`timescale 1ns/100ps
`default_nettype none
`include "ipv_irq_regs.vh"
module ipv_irq_ctrl_tb_top;
  localparam logic [4:0] PM [32] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h01,
    5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0c, 5'h0e, 5'h0f, 5'h11, 5'h12,
    5'h0a, 5'h0b, 5'h0d, 5'h10, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00};
  localparam logic [15:0] VT [25] = '{16'hfff2, 16'hfff0, 16'hffee, 16'hffec, 16'hffea,
    16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0, 16'hffd4, 16'hffd2, 16'hffde, 16'hffd0,
    16'hffdc, 16'hffda, 16'hffce, 16'hffd8, 16'hffd6, 16'hfff4, 16'hfff8, 16'hfff6, 16'hfffa,
    16'hfffc, 16'hfffe};
  // {pend, src, cfg, xMask, nmi, swi, illegal, cop, clkmon, reset}
  localparam logic [14:0] FX [9] = '{{1'b1, 5'h15, 9'h010}, {1'b1, 5'h14, 9'h018},
    {1'b1, 5'h13, 9'h028}, {1'b0, 5'h00, 9'h060}, {1'b1, 5'h16, 9'h004}, {1'b0, 5'h00, 9'h084},
    {1'b1, 5'h17, 9'h186}, {1'b0, 5'h00, 9'h002}, {1'b1, 5'h18, 9'h001}};
  logic clk, resetn, hsel, hwrite, condI, condX, nmiN, swi, ill, cop, cmf, rst, dataOnly;
  logic [31:0] haddr, hwdata, rd, seed;
  logic [1:0] htrans, rxSet, rdKick;
  logic [2:0] hsize, pick;
  logic [18:0] req;
  wire hreadyout, hresp, pend;
  wire [31:0] hrdata;
  wire [4:0] src;
  wire [15:0] vHi, vLo;
  wire [1:0] rxFull, stRd, dtRd;
  wire [2:0] modF;
  wire [7:0] phF, ev;
  int fails = 0;
  int nTests = 0;
  int cyc = 0;
  ipv_irq_ctrl dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .condCodeIBit(condI), .condCodeXBit(condX),
    .irqPinN(!req[0]), .nonmaskablePinN(nmiN), .swiReq(swi), .illegalOpReq(ill), .copFail(cop),
    .clockMonFail(cmf), .resetReq(rst), .rtiFlag(req[1]), .captureFlag(req[4:2]),
    .compareFlag(req[8:5]), .cap4Cmp5Flag(req[9]), .timerOvfFlag(req[12]),
    .accumOvfFlag(req[14]), .accumEdgeFlag(req[15]), .modTimerFlag(modF), .porthFlag(phF),
    .sync1DoneFlag(req[17]), .sync2DoneFlag(req[10]), .asyncRxSet(rxSet),
    .asyncStatusRd(stRd), .asyncDataRd(dtRd), .asyncOverrun({ev[4], ev[0]}),
    .asyncTxEmpty({ev[5], ev[1]}), .asyncTxDone({ev[6], ev[2]}), .asyncIdle({ev[7], ev[3]}),
    .rxFullFlag(rxFull), .irqPending_ff(pend), .srcCode_ff(src), .vecHiAddr_ff(vHi),
    .vecLoAddr_ff(vLo));
  ipv_src_model peer (.clk(clk), .req(req), .pick(pick), .rdKick(rdKick), .dataOnly(dataOnly),
    .modFlag(modF), .porthFlag(phF), .asyncEv(ev), .statusRd(stRd), .dataRd(dtRd));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      final_report();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    repeat (32) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  // local enable of each maskable source code
  function automatic logic [18:0] enOf(input logic [11:0] t, input logic [13:0] s,
      input logic [7:0] h, input logic [2:0] k);
    logic [1:0] m;
    m = (k[1:0] == 2'd0) ? 2'd0 : (k[1:0] == 2'd1) ? 2'd1 : 2'd2;
    return {s[k[1:0]], s[8], h[k], t[10], t[9], s[10 + m], t[8], s[4 + k[1:0]], s[9], t[7:0],
      t[11], 1'b1};
  endfunction
  function automatic logic [4:0] winOf(input logic [18:0] e, input logic [4:0] p);
    if (e[p])
      return p;
    for (int i = 0; i < 19; i++)
      if (e[i])
        return i[4:0];
    return 5'h00;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a, 2'b00};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic final_report;
    if (fails == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    logic [11:0] te;
    logic [13:0] se;
    logic [7:0] ph;
    logic [4:0] p, w;
    logic [18:0] eff;
    logic iBit, expP;
    logic [14:0] fx;
    {hsel, hwrite, swi, ill, cop, cmf, rst, dataOnly, condX} = '0;
    {haddr, hwdata, htrans, rxSet, rdKick, pick, req} = '0;
    {resetn, nmiN, condI} = 3'b011;
    hsize = 3'b010;
    seed = 32'h472d;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(1'b0, `IPV_OFF_PRIO, 32'h0, rd);
    chk(rd, 32'h6);
    condI <= 1'b0;
    bus(1'b1, `IPV_OFF_PRIO, 32'h10, rd);
    bus(1'b1, 6'h3f, 32'hffff_ffff, rd);
    bus(1'b0, `IPV_OFF_PRIO, 32'h0, rd);
    chk(rd, 32'h6);
    bus(1'b0, 6'h3f, 32'h0, rd);
    chk(rd, 32'h0);
    repeat (40)
    begin
      seed = lfsr(seed);
      {ph, se} = seed[21:0];
      seed = lfsr(seed);
      te = seed[31:20];
      p = seed[4:0];
      iBit = (seed[8:5] == 4'h0);
      condI <= 1'b1;
      @(posedge clk);
      bus(1'b1, `IPV_OFF_PRIO, {27'h0, p}, rd);
      bus(1'b1, `IPV_OFF_TMREN, {20'h0, te}, rd);
      bus(1'b1, `IPV_OFF_SEREN, {18'h0, se}, rd);
      bus(1'b1, `IPV_OFF_PHEN, {24'h0, ph}, rd);
      seed = lfsr(seed);
      req <= seed[18:0] & seed[31:13];
      pick <= seed[21:19];
      condI <= iBit;
      repeat (3) @(posedge clk);
      eff = req & enOf(te, se, ph, pick);
      w = winOf(eff, PM[p]);
      expP = !iBit && (eff != 19'h0);
      chk(pend, expP);
      chk(pend ? {src, vHi} : 21'h0, expP ? {w, VT[w]} : 21'h0);
      chk(pend ? vLo : 16'h0, expP ? (VT[w] | 16'h0001) : 16'h0);
      bus(1'b0, `IPV_OFF_STAT, 32'h0, rd);
      chk(rd[24], expP);
    end
    req <= '0;
    condI <= 1'b1;
    foreach (FX[i])
    begin
      fx = FX[i];
      bus(1'b1, `IPV_OFF_CFG, {30'h0, fx[8:7]}, rd);
      {condX, nmiN, swi, ill, cop, cmf, rst} <= fx[6:0] ^ 7'b0100000;
      repeat (3) @(posedge clk);
      chk({pend, src, vHi}, {fx[14:9], VT[fx[13:9]]});
    end
    {condX, nmiN, swi, ill, cop, cmf, rst} <= 7'b0100000;
    for (int u = 0; u < 2; u++)
    begin
      rxSet <= 2'b01 << u;
      @(posedge clk);
      rxSet <= 2'b00;
      dataOnly <= 1'b1;
      rdKick <= 2'b01 << u;
      @(posedge clk);
      rdKick <= 2'b00;
      @(posedge clk);
      dataOnly <= 1'b0;
      chk(rxFull, 2'b01 << u);
      rdKick <= 2'b01 << u;
      @(posedge clk);
      rdKick <= 2'b00;
      repeat (3) @(posedge clk);
      chk(rxFull, 2'b00);
    end
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(1'b0, `IPV_OFF_PRIO, 32'h0, rd);
    chk(rd, 32'h6);
    bus(1'b0, `IPV_OFF_TMREN, 32'h0, rd);
    chk(rd, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire

// ### sim/ipv_src_model.sv
// shared-vector peripheral sources and receive handler reads
`timescale 1ns/100ps
`default_nettype none
module ipv_src_model
(
  input wire logic clk,
  input wire logic [18:0] req,
  input wire logic [2:0] pick,
  input wire logic [1:0] rdKick,
  input wire logic dataOnly,
  output logic [2:0] modFlag,
  output logic [7:0] porthFlag,
  output logic [7:0] asyncEv,
  output logic [1:0] statusRd,
  output logic [1:0] dataRd
);
  logic [1:0] armed = 2'b00;
  wire [3:0] oneHot = 4'b0001 << pick[1:0];
  assign modFlag = {3{req[13]}} & (pick[1:0] == 2'd0 ? 3'b001 : pick[1:0] == 2'd1 ? 3'b010 : 3'b100);
  assign porthFlag = {8{req[16]}} & (8'h01 << pick);
  // per unit: {idle, tx done, tx empty, overrun}
  assign asyncEv = {oneHot & {4{req[11]}}, oneHot & {4{req[18]}}};
  // handler reads status, then data one cycle later
  assign statusRd = dataOnly ? 2'b00 : rdKick;
  assign dataRd = dataOnly ? rdKick : armed;
  always @(posedge clk)
    armed <= rdKick;
endmodule
`default_nettype wire
